// ### oar_map.vh
`ifndef OAR_MAP_VH
`define OAR_MAP_VH

// Message framing bytes
`define OAR_FC 8'h2b
`define OAR_FC_ERR 8'hab
`define OAR_MEI 8'h0d
`define OAR_EXC_EXT 8'hff
`define OAR_EXC_OPT 8'hae
`define OAR_EXC_CODE 8'hce
`define OAR_EXT_LEN_OPT 16'h0003
`define OAR_EXT_LEN_CODE 16'h0006
`define OAR_PC_SUPPORTED 8'he1
`define OAR_ZERO 8'h00

// Control bit n sits at byte bit n, bit 7 is the MSB
`define OAR_PC_MULTI 7
`define OAR_PC_EXT 6
`define OAR_PC_CNT 5
`define OAR_PC_NET_IDENT_OPT 2
`define OAR_PC_ENC_OPT 1
`define OAR_PC_WRITE 0

// Field ranges
`define OAR_STN_MIN 8'h01
`define OAR_STN_MAX 8'h7f
`define OAR_NVAL_MAX 16'h00fd

// Error codes
`define OAR_CODE_SEQ 32'hffff1004
`define OAR_CODE_PARAM 32'hffff000e
`define OAR_CODE_SHORT 32'hffff0013

// Response buffer
`define OAR_BUF_DEPTH 20
`define OAR_LEN_OPT 5'd7
`define OAR_LEN_CODE 5'd10
`define OAR_DATA_MAX 3'd4

// Register byte offsets
`define OAR_REG_CTRL 8'h00
`define OAR_REG_STATUS 8'h04
`define OAR_REG_MASK 8'h08
`define OAR_REG_ADDR 8'h0c
`define OAR_REG_XFER 8'h10
`define OAR_REG_WDATA 8'h14
`define OAR_REG_RDATA 8'h18
`define OAR_REG_RLEN 8'h1c
`define OAR_REG_PCTRL 8'h20

// Status bits and reset values
`define OAR_ST_WRITE 0
`define OAR_ST_READ 1
`define OAR_ST_OPT 2
`define OAR_ST_SEQ 3
`define OAR_ST_PARAM 4
`define OAR_ST_W 5
`define OAR_CTRL_RST 1'b1
`define OAR_RLEN_RST 3'd4

`endif

// ### resp_tx.v
`timescale 1ns/100ps
`default_nettype none

module resp_tx (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [4:0] len,
  input wire [7:0] byte_in,
  output wire [4:0] idx,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_last,
  input wire tx_ready,
  output reg done
);

  reg [4:0] idx_r;
  reg [4:0] len_r;
  reg active_r;
  wire load;

  assign idx = idx_r;
  // Next byte may be staged whenever the output slot is empty or being taken
  assign load = active_r && (idx_r < len_r) && (!tx_valid || tx_ready);

  // Byte serialiser, one byte per accepted handshake
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= 5'h00;
      len_r <= 5'h00;
      active_r <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        idx_r <= 5'h00;
        len_r <= len;
        active_r <= 1'b1;
      end else if (load) begin
        tx_data <= byte_in;
        tx_valid <= 1'b1;
        tx_last <= ((idx_r + 5'h01) == len_r);
        idx_r <= idx_r + 5'h01;
      end else if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        if (tx_last) begin
          active_r <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // resp_tx

`default_nettype wire

// ### object_access_request_parser.v
`timescale 1ns/100ps
`default_nettype none
`include "oar_map.vh"

module object_access_request_parser (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  output wire rx_ready,
  output wire tx_valid,
  output wire [7:0] tx_data,
  output wire tx_last,
  input wire tx_ready,
  output reg irq
);

  localparam ST_FC = 4'h0;
  localparam ST_MEI = 4'h1;
  localparam ST_PC1 = 4'h2;
  localparam ST_PC2 = 4'h3;
  localparam ST_RSV = 4'h4;
  localparam ST_CNT = 4'h5;
  localparam ST_ADDR = 4'h6;
  localparam ST_DATA = 4'h7;
  localparam ST_DROP = 4'h8;
  localparam ST_RESP = 4'h9;
  localparam ST_SEND = 4'ha;

  localparam ERR_NONE = 2'd0;
  localparam ERR_OPT = 2'd1;
  localparam ERR_CODE = 2'd2;

  reg rst_meta_r;
  reg rst_n_r;
  reg [3:0] state_r;
  reg [2:0] fcnt_r;
  reg [4:0] hlen_r;
  reg [7:0] rbuf [0:`OAR_BUF_DEPTH-1];
  reg [7:0] pc1_r;
  reg [7:0] pc2_r;
  reg [7:0] cnt_prev_r;
  reg cnt_seen_r;
  reg [7:0] station_number_r;
  reg [15:0] index_r;
  reg [7:0] subindex_r;
  reg [15:0] start_r;
  reg [15:0] nval_r;
  reg [31:0] wdata_r;
  reg [7:0] wcnt_r;
  reg multi_prev_r;
  reg [1:0] err_r;
  reg [31:0] code_r;
  reg [4:0] resp_len_r;
  reg tx_start_r;
  reg [`OAR_ST_W-1:0] evt_r;
  reg [`OAR_ST_W-1:0] status_r;
  reg [`OAR_ST_W-1:0] mask_r;
  reg enable_r;
  reg [31:0] rdata_r;
  reg [2:0] rlen_r;
  reg [31:0] rd_mux;
  reg hit;
  wire rx_take;
  wire tx_done;
  wire [4:0] tx_idx;
  wire short_msg;
  wire is_write;
  wire apb_wr;
  wire apb_rd;
  wire [`OAR_ST_W-1:0] status_nxt;
  wire [`OAR_ST_W-1:0] mask_nxt;
  wire [15:0] ext_len_opt;
  wire [15:0] ext_len_code;
  integer k;

  // Two-flop release so the parser never leaves reset on a metastable edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Input stalls while an answer is pending, so requests never overlap
  assign rx_ready = (state_r != ST_RESP) && (state_r != ST_SEND);
  assign rx_take = rx_valid && rx_ready;
  assign is_write = pc1_r[`OAR_PC_WRITE];
  // Message ended before the value count was complete
  assign short_msg = (state_r != ST_DATA) && !((state_r == ST_ADDR) && (fcnt_r == 3'd7));
  // Length words split into bytes by part-select, not by shifting a wider value
  assign ext_len_opt = `OAR_EXT_LEN_OPT;
  assign ext_len_code = `OAR_EXT_LEN_CODE;

  // Request parser and response builder
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_FC;
      fcnt_r <= 3'd0;
      hlen_r <= 5'h00;
      pc1_r <= 8'h00;
      pc2_r <= 8'h00;
      cnt_prev_r <= 8'h00;
      cnt_seen_r <= 1'b0;
      station_number_r <= 8'h00;
      index_r <= 16'h0000;
      subindex_r <= 8'h00;
      start_r <= 16'h0000;
      nval_r <= 16'h0000;
      wdata_r <= 32'h00000000;
      wcnt_r <= 8'h00;
      multi_prev_r <= 1'b0;
      err_r <= ERR_NONE;
      code_r <= 32'h00000000;
      resp_len_r <= 5'h00;
      tx_start_r <= 1'b0;
      evt_r <= {`OAR_ST_W{1'b0}};
    end else begin
      tx_start_r <= 1'b0;
      evt_r <= {`OAR_ST_W{1'b0}};
      if (rx_take && (state_r <= ST_ADDR) && (hlen_r < `OAR_BUF_DEPTH)) begin
        rbuf[hlen_r] <= rx_data;
        hlen_r <= hlen_r + 5'h01;
      end
      if (rx_take && rx_last && (state_r != ST_DROP) && (state_r != ST_FC) && (state_r != ST_MEI)
          && short_msg && (err_r == ERR_NONE)) begin
        err_r <= ERR_CODE;
        code_r <= `OAR_CODE_SHORT;
      end
      case (state_r)
        ST_FC: begin
          if (rx_take) begin
            if (!multi_prev_r) begin
              wcnt_r <= 8'h00;
              wdata_r <= 32'h00000000;
            end
            if ((rx_data == `OAR_FC) && enable_r && !rx_last)
              state_r <= ST_MEI;
            else
              state_r <= rx_last ? ST_FC : ST_DROP;
            if (rx_last)
              hlen_r <= 5'h00;
          end
        end
        ST_MEI: begin
          if (rx_take) begin
            if ((rx_data == `OAR_MEI) && !rx_last)
              state_r <= ST_PC1;
            else
              state_r <= rx_last ? ST_FC : ST_DROP;
            if (rx_last)
              hlen_r <= 5'h00;
          end
        end
        ST_PC1: begin
          if (rx_take) begin
            pc1_r <= rx_data;
            pc2_r <= 8'h00;
            if (rx_data[`OAR_PC_NET_IDENT_OPT] || rx_data[`OAR_PC_ENC_OPT])
              err_r <= ERR_OPT;
            state_r <= rx_data[`OAR_PC_EXT] ? ST_PC2 : ST_RSV;
          end
        end
        ST_PC2: begin
          if (rx_take) begin
            pc2_r <= rx_data;
            state_r <= ST_RSV;
          end
        end
        ST_RSV: begin
          if (rx_take) begin
            fcnt_r <= 3'd0;
            state_r <= pc1_r[`OAR_PC_CNT] ? ST_CNT : ST_ADDR;
          end
        end
        ST_CNT: begin
          if (rx_take) begin
            if (cnt_seen_r && (rx_data != (cnt_prev_r + 8'h01)) && (err_r == ERR_NONE)) begin
              err_r <= ERR_CODE;
              code_r <= `OAR_CODE_SEQ;
            end
            cnt_prev_r <= rx_data;
            cnt_seen_r <= 1'b1;
            state_r <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (rx_take) begin
            fcnt_r <= fcnt_r + 3'd1;
            case (fcnt_r)
              3'd0: begin
                station_number_r <= rx_data;
                if (((rx_data < `OAR_STN_MIN) || (rx_data > `OAR_STN_MAX)) &&
                    (err_r == ERR_NONE)) begin
                  err_r <= ERR_CODE;
                  code_r <= `OAR_CODE_PARAM;
                end
              end
              3'd1: index_r[15:8] <= rx_data;
              3'd2: index_r[7:0] <= rx_data;
              3'd3: subindex_r <= rx_data;
              3'd4: start_r[15:8] <= rx_data;
              3'd5: start_r[7:0] <= rx_data;
              3'd6: nval_r[15:8] <= rx_data;
              default: begin
                nval_r[7:0] <= rx_data;
                if (({nval_r[15:8], rx_data} > `OAR_NVAL_MAX) && (err_r == ERR_NONE)) begin
                  err_r <= ERR_CODE;
                  code_r <= `OAR_CODE_PARAM;
                end
                state_r <= ST_DATA;
              end
            endcase
          end
        end
        ST_DATA: begin
          if (rx_take && is_write) begin
            if (wcnt_r < {5'h00, `OAR_DATA_MAX})
              wdata_r[{wcnt_r[1:0], 3'b000} +: 8] <= rx_data;
            if (wcnt_r != 8'hff)
              wcnt_r <= wcnt_r + 8'h01;
          end
        end
        ST_RESP: begin
          tx_start_r <= 1'b1;
          state_r <= ST_SEND;
          rbuf[0] <= `OAR_FC_ERR;
          rbuf[1] <= `OAR_EXC_EXT;
          rbuf[4] <= `OAR_MEI;
          if (err_r == ERR_OPT) begin
            rbuf[2] <= ext_len_opt[15:8];
            rbuf[3] <= ext_len_opt[7:0];
            rbuf[5] <= `OAR_EXC_OPT;
            rbuf[6] <= `OAR_PC_SUPPORTED;
            resp_len_r <= `OAR_LEN_OPT;
            evt_r[`OAR_ST_OPT] <= 1'b1;
            multi_prev_r <= 1'b0;
          end else if (err_r == ERR_CODE) begin
            rbuf[2] <= ext_len_code[15:8];
            rbuf[3] <= ext_len_code[7:0];
            rbuf[5] <= `OAR_EXC_CODE;
            for (k = 0; k < 4; k = k + 1)
              rbuf[6 + k] <= code_r[(31 - 8 * k) -: 8];
            resp_len_r <= `OAR_LEN_CODE;
            evt_r[`OAR_ST_SEQ] <= (code_r == `OAR_CODE_SEQ);
            evt_r[`OAR_ST_PARAM] <= (code_r != `OAR_CODE_SEQ);
            multi_prev_r <= 1'b0;
          end else if (is_write) begin
            // Header already echoed as received; only the count goes to zero
            rbuf[0] <= `OAR_FC;
            rbuf[1] <= `OAR_MEI;
            rbuf[4] <= rbuf[4];
            rbuf[hlen_r - 5'h02] <= `OAR_ZERO;
            rbuf[hlen_r - 5'h01] <= `OAR_ZERO;
            resp_len_r <= hlen_r;
            multi_prev_r <= pc1_r[`OAR_PC_MULTI];
            evt_r[`OAR_ST_WRITE] <= !pc1_r[`OAR_PC_MULTI];
          end else begin
            rbuf[0] <= `OAR_FC;
            rbuf[1] <= `OAR_MEI;
            rbuf[4] <= rbuf[4];
            rbuf[hlen_r - 5'h02] <= `OAR_ZERO;
            rbuf[hlen_r - 5'h01] <= {5'h00, rlen_r};
            for (k = 0; k < 4; k = k + 1)
              rbuf[hlen_r + k[4:0]] <= rdata_r[8 * k +: 8];
            resp_len_r <= hlen_r + {2'b00, rlen_r};
            evt_r[`OAR_ST_READ] <= 1'b1;
            multi_prev_r <= 1'b0;
          end
        end
        ST_SEND: begin
          if (tx_done) begin
            state_r <= ST_FC;
            hlen_r <= 5'h00;
            err_r <= ERR_NONE;
          end
        end
        default: begin
          if (rx_take && rx_last) begin
            state_r <= ST_FC;
            hlen_r <= 5'h00;
          end
        end
      endcase
      // End of a parsed message hands over to the answer
      if (rx_take && rx_last && (state_r >= ST_PC1) && (state_r <= ST_DATA))
        state_r <= ST_RESP;
    end
  end

  resp_tx u_tx (
    .clk(clk),
    .rst_n(rst_n_r),
    .start(tx_start_r),
    .len(resp_len_r),
    .byte_in(rbuf[tx_idx]),
    .idx(tx_idx),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .done(tx_done)
  );

  // APB slave: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite && hit;
  assign apb_rd = psel && penable && !pwrite && hit;
  assign pslverr = psel && penable && !hit;
  // Irq follows the next status and mask, so it drops with the clearing access itself
  assign status_nxt = (apb_rd && (paddr == `OAR_REG_STATUS)) ? evt_r : (status_r | evt_r);
  assign mask_nxt = (apb_wr && (paddr == `OAR_REG_MASK)) ? pwdata[`OAR_ST_W-1:0] : mask_r;

  // Read mux and decode
  always @* begin
    hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `OAR_REG_CTRL: rd_mux = {31'h00000000, enable_r};
      `OAR_REG_STATUS: rd_mux = {27'h0000000, status_r};
      `OAR_REG_MASK: rd_mux = {27'h0000000, mask_r};
      `OAR_REG_ADDR: rd_mux = {index_r, subindex_r, station_number_r};
      `OAR_REG_XFER: rd_mux = {start_r, nval_r};
      `OAR_REG_WDATA: rd_mux = wdata_r;
      `OAR_REG_RDATA: rd_mux = rdata_r;
      `OAR_REG_RLEN: rd_mux = {29'h00000000, rlen_r};
      `OAR_REG_PCTRL: rd_mux = {8'h00, cnt_prev_r, pc1_r, pc2_r};
      default: hit = 1'b0;
    endcase
  end

  // Software registers; status is read-to-clear and a new event wins
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata <= 32'h00000000;
      enable_r <= `OAR_CTRL_RST;
      mask_r <= {`OAR_ST_W{1'b0}};
      status_r <= {`OAR_ST_W{1'b0}};
      rdata_r <= 32'h00000000;
      rlen_r <= `OAR_RLEN_RST;
      irq <= 1'b0;
    end else begin
      if (psel && !penable)
        prdata <= rd_mux;
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_nxt);
      if (apb_wr) begin
        case (paddr)
          `OAR_REG_CTRL: enable_r <= pwdata[0];
          `OAR_REG_MASK: mask_r <= pwdata[`OAR_ST_W-1:0];
          `OAR_REG_RDATA: rdata_r <= pwdata;
          `OAR_REG_RLEN: rlen_r <= (pwdata[2:0] > `OAR_DATA_MAX) ? `OAR_DATA_MAX : pwdata[2:0];
          default: enable_r <= enable_r;
        endcase
      end
    end
  end

endmodule // object_access_request_parser

`default_nettype wire

// ### oar_props.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the parser; one clock domain throughout
module oar_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Bus side
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase not ready");
  property p_slverr; pslverr |-> psel && penable; endproperty
  a_slverr: assert property (p_slverr) else $error("bus error outside access");
  // Irq only drops as a result of a bus access
  property p_irq; $fell(irq) |-> $past(psel); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped with no access");
  // Answer stream
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("answer byte changed while stalled");
  property p_head; $rose(tx_valid) |-> tx_data == 8'h2b || tx_data == 8'hab; endproperty
  a_head: assert property (p_head) else $error("answer has wrong function code");
  property p_busy; tx_valid |-> !rx_ready; endproperty
  a_busy: assert property (p_busy) else $error("request taken while answering");
  property p_lat; rx_valid && rx_ready && rx_last |=> !tx_valid [*2]; endproperty
  a_lat: assert property (p_lat) else $error("answer came too early");
  property p_free; tx_valid && tx_ready && tx_last |=> !tx_valid ##[0:2] rx_ready; endproperty
  a_free: assert property (p_free) else $error("link not freed after answer");
  c_ack: cover property (tx_valid && tx_ready && tx_last);
  c_stall: cover property (tx_valid && !tx_ready);
  c_irq: cover property ($rose(irq));
endmodule // oar_props
bind object_access_request_parser oar_props u_oar_props (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_ready(tx_ready), .irq(irq));
`default_nettype wire

// ### oar_master.sv
`timescale 1ns/100ps
`default_nettype none
// Network master stand-in: sends request bytes, collects answer bytes
module oar_master (
  input wire logic clk,
  input wire logic slow,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic ph = 1'b0;
  int last_at = -1;
  logic stuck = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // When slow, take only every other cycle so the answer must wait
  always @(posedge clk) begin
    ph <= ~ph;
    tx_ready <= !slow || ph;
    if (tx_valid && tx_ready && tx_last)
      last_at <= got.size();
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end
  // Bytes go out in message order, each held until taken
  task automatic send(input logic [7:0] m[$]);
    int k;
    foreach (m[i]) begin
      k = 0;
      rx_valid <= 1'b1;
      rx_data <= m[i];
      rx_last <= i == m.size() - 1;
      do @(posedge clk); while (!rx_ready && ++k < 300);
      if (k >= 300) stuck = 1'b1;
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data; // Released line must not show a stale byte
  endtask
endmodule // oar_master
`default_nettype wire

// ### object_access_request_parser_test.sv
`timescale 1ns/100ps
`default_nettype none
module object_access_request_parser_test;
  typedef logic [7:0] q_t[$];
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, irq;
  logic [7:0] rx_data, tx_data;
  int n_fail = 0, checks = 0;
  integer seed = 32'h56b11acc;
  always #4 clk = ~clk;
  object_access_request_parser u_object_access_request_parser (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .irq(irq));
  oar_master u_oar_master (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    n_fail++;
    tally_and_finish();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer, request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready && ++k < 50);
    if (!pready) timeout();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, d, r, x);
  endtask
  // Offsets past the last register are unmapped and must error
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic x;
    apb(1'b0, a, 32'h0, r, x);
    chk(nm, e, r);
    chk("slverr", {31'h0, a > 8'h20}, {31'h0, x});
  endtask
  // Request bytes in wire order; optional bytes only when their bit is set
  function automatic q_t msg(input logic [7:0] pc, c2, ct, sn, input logic [15:0] ix,
                             input logic [7:0] sb, input logic [15:0] sa, n);
    q_t m;
    m = '{8'h2b, 8'h0d, pc};
    if (pc[6]) m.push_back(c2);
    m.push_back(8'h00);
    if (pc[5]) m.push_back(ct);
    m = {m, sn, ix[15:8], ix[7:0], sb, sa[15:8], sa[7:0], n[15:8], n[7:0]};
    return m;
  endfunction
  function automatic q_t oe();
    return '{8'hab, 8'hff, 8'h00, 8'h03, 8'h0d, 8'hae, 8'he1};
  endfunction
  function automatic q_t ce(input logic [31:0] c);
    return '{8'hab, 8'hff, 8'h00, 8'h06, 8'h0d, 8'hce, c[31:24], c[23:16], c[15:8], c[7:0]};
  endfunction
  // Send a request, compare the whole answer, then read and clear status
  task automatic run(input q_t m, input q_t e, input logic [4:0] st);
    int k;
    k = 0;
    chk("irq idle", 32'h0, {31'h0, irq});
    u_oar_master.got.delete();
    u_oar_master.last_at = -1;
    u_oar_master.send(m);
    if (u_oar_master.stuck) timeout();
    while (u_oar_master.got.size() < e.size() && ++k < 300) @(posedge clk);
    if (k == 300) timeout();
    repeat (8) @(posedge clk);
    chk("answer length", 32'(e.size()), 32'(u_oar_master.got.size()));
    chk("answer last", 32'(e.size()) - 32'h1, 32'(u_oar_master.last_at));
    foreach (e[i]) chk("answer byte", {24'h0, e[i]}, {24'h0, u_oar_master.got[i]});
    chk("irq", {31'h0, st != 5'h0}, {31'h0, irq});
    rdc("status", 8'h04, {27'h0, st});
    repeat (2) @(posedge clk);
  endtask
  // A good write is answered by its header echoed with a zero count
  task automatic wr(input logic [7:0] pc, c2, ct, sn, input logic [15:0] ix,
                    input logic [7:0] sb, input q_t d, input logic [4:0] st);
    run({msg(pc, c2, ct, sn, ix, sb, 16'h0, 16'(d.size())), d},
        msg(pc, c2, ct, sn, ix, sb, 16'h0, 16'h0), st);
  endtask
  task automatic bad(input q_t m, input int p, input logic [7:0] v, input q_t e,
                     input logic [4:0] st);
    m[p] = v;
    run(m, e, st);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    timeout();
  end
  initial begin
    logic [31:0] r, w;
    logic [7:0] sn;
    q_t d, m, none;
    logic [15:0] sx[5] = '{16'h6060, 16'h2031, 16'h6040, 16'h6040, 16'h6040};
    logic [31:0] vx[5] = '{32'h02, 32'h3e8, 32'h00, 32'h80, 32'h06};
    int cx[5] = '{1, 4, 2, 2, 2};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("ctrl", 8'h00, 32'h1);
    rdc("mask", 8'h08, 32'h0);
    rdc("rlen", 8'h1c, 32'h4);
    rdc("unmapped", 8'h24, 32'h0);
    wreg(8'h08, 32'h1f);
    // Constant-speed sequence: mode, current limit, then control word steps
    for (int i = 0; i < 5; i++) begin
      d = {};
      for (int j = 0; j < cx[i]; j++) d.push_back(8'(vx[i] >> (8 * j)));
      wr(8'h01, 8'h0, 8'h0, 8'h01, sx[i], 8'h0, d, 5'h01);
      if (i == 1) rdc("wdata", 8'h14, 32'h3e8);
    end
    // Random writes, station range ends first
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      w = $random(seed);
      sn = i == 0 ? 8'h01 : i == 1 ? 8'h7f : r[7:0] % 8'h7f + 8'h01;
      d = {};
      for (int j = 0; j <= w[1:0]; j++) d.push_back(8'($random(seed)));
      wr(8'h01, 8'h0, 8'h0, sn, r[23:8], r[31:24], d, 5'h01);
      rdc("addr", 8'h0c, {r[23:8], r[31:24], sn});
      rdc("xfer", 8'h10, {16'h0, 13'h0, 3'(w[1:0]) + 3'h1});
    end
    // Reads of every length, with the sink stalling on odd ones
    for (int k = 0; k < 5; k++) begin
      w = $random(seed);
      wreg(8'h18, w);
      wreg(8'h1c, 32'(k));
      slow <= k[0];
      d = {};
      for (int j = 0; j < k; j++) d.push_back(w[8 * j +: 8]);
      run(msg(8'h00, 8'h0, 8'h0, 8'h05, 16'h6041, 8'h0, 16'h0, 16'h0),
          {msg(8'h00, 8'h0, 8'h0, 8'h05, 16'h6041, 8'h0, 16'h0, 16'(k)), d}, 5'h02);
    end
    slow <= 1'b0;
    wreg(8'h1c, 32'h7);
    rdc("rlen", 8'h1c, 32'h4);
    d = '{8'h11};
    wr(8'h41, 8'h00, 8'h0, 8'h02, 16'h1000, 8'h01, d, 5'h01);
    wr(8'h21, 8'h0, 8'h05, 8'h02, 16'h6040, 8'h0, d, 5'h01);
    wr(8'h21, 8'h0, 8'h06, 8'h02, 16'h6040, 8'h0, d, 5'h01);
    m = {msg(8'h21, 8'h0, 8'h06, 8'h02, 16'h6040, 8'h0, 16'h0, 16'h1), d};
    bad(m, 4, 8'h08, ce(32'hffff1004), 5'h08);
    rdc("pctrl", 8'h20, 32'h00082100);
    // Faulty requests made on purpose
    m = {msg(8'h01, 8'h0, 8'h0, 8'h01, 16'h6040, 8'h0, 16'h0, 16'h1), d};
    bad(m, 4, 8'h80, ce(32'hffff000e), 5'h10);
    bad(m, 4, 8'h00, ce(32'hffff000e), 5'h10);
    bad(m, 11, 8'hfe, ce(32'hffff000e), 5'h10);
    bad(m, 2, 8'h05, oe(), 5'h04);
    bad(m, 2, 8'h03, oe(), 5'h04);
    bad(m, 0, 8'h2c, none, 5'h00);
    bad(m, 1, 8'h0e, none, 5'h00);
    run(m[0:8], ce(32'hffff0013), 5'h10);
    wreg(8'h00, 32'h0);
    run(m, none, 5'h00);
    wreg(8'h00, 32'h1);
    // Two-part write is put back together in order
    w = $random(seed);
    wr(8'h81, 8'h0, 8'h0, 8'h03, 16'h2031, 8'h0, '{w[7:0], w[15:8]}, 5'h00);
    wr(8'h01, 8'h0, 8'h0, 8'h03, 16'h2031, 8'h0, '{w[23:16], w[31:24]}, 5'h01);
    rdc("wdata", 8'h14, w);
    tally_and_finish();
  end
endmodule // object_access_request_parser_test
`default_nettype wire
